// [hw/i2cx_host.sv]
/*
  Controller end: I2C master driven by software over AXI4-Lite.
  One command word runs an optional start, an optional byte and an
  optional stop. Assumes no clock stretching by slaves.
*/
module i2cx_host
  import i2cx_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER_CYC
) (
  input logic aclk, // System clock
  input logic aresetn, // Synchronous reset, active low
  i2cx_if.host bus, // Two-wire bus
  input logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input logic [3:0] awaddr, // Write address
  input logic wvalid, // Write data valid
  output logic wready, // Write data ready
  input logic [31:0] wdata, // Write data
  input logic [3:0] wstrb, // Write strobes
  output logic bvalid, // Write response valid
  input logic bready, // Write response ready
  output logic [1:0] bresp, // Write response
  input logic arvalid, // Read address valid
  output logic arready, // Read address ready
  input logic [3:0] araddr, // Read address
  output logic rvalid, // Read data valid
  input logic rready, // Read data ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp // Read response
);
  logic s1, s2, s3, sda_f;
  logic [15:0] div;
  logic tick;

  i2cx_host_state_t state, next_state;
  logic [1:0] q, next_q;
  logic [3:0] bitn, next_bitn;
  logic [7:0] tx, next_tx, rx, next_rx;
  logic do_byte, next_do_byte, do_stop, next_do_stop, rd, next_rd, mack, next_mack;
  logic nack, next_nack, scl_oe, next_scl_oe, sda_oe, next_sda_oe;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  always_ff @(posedge aclk) begin
    s1 <= bus.sda;
    s2 <= s1;
    s3 <= s2;
    if (s2 == s3) begin
      sda_f <= s3;
    end
    if (!aresetn || tick) begin
      div <= 16'h0;
    end else begin
      div <= div + 16'h1;
    end
  end

  assign tick = (div == 16'(QUARTER - 1));

  always_comb begin
    next_state = state;
    next_q = q;
    next_bitn = bitn;
    next_tx = tx;
    next_rx = rx;
    next_do_byte = do_byte;
    next_do_stop = do_stop;
    next_rd = rd;
    next_mack = mack;
    next_nack = nack;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    // Bus sequencer, one step per quarter bit
    if (state != HS_IDLE && tick) begin
      next_q = q + 2'h1;
      case (state)
        HS_START: begin
          case (q)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            default: begin
              next_scl_oe = 1'b1;
              next_bitn = 4'h0;
              next_state = do_byte ? HS_BIT : (do_stop ? HS_STOP : HS_IDLE);
            end
          endcase
        end
        HS_BIT: begin
          case (q)
            2'h0: begin
              if (bitn == 4'h8) begin
                next_sda_oe = rd && mack;
              end else begin
                next_sda_oe = !rd && !tx[7];
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn == 4'h8) begin
                next_nack = sda_f;
              end else begin
                next_rx = {rx[6:0], sda_f};
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              next_tx = {tx[6:0], 1'b0};
              next_bitn = bitn + 4'h1;
              if (bitn == 4'h8) begin
                next_sda_oe = 1'b0;
                next_state = do_stop ? HS_STOP : HS_IDLE;
              end
            end
          endcase
        end
        HS_STOP: begin
          case (q)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default: next_state = HS_IDLE;
          endcase
        end
        default: next_state = HS_IDLE;
      endcase
    end
    // Register write once address and data are both held
    if (next_aw_held && next_w_held && !next_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_SLVERR;
      if (next_aw_addr == HOST_CMD_OFS || next_aw_addr == HOST_STAT_OFS) begin
        next_bresp = RESP_OKAY;
      end
      // Commands while busy are dropped
      if (next_aw_addr == HOST_CMD_OFS && next_w_strb[0] && state == HS_IDLE) begin
        next_do_byte = next_w_data[CMD_BYTE_BIT];
        next_do_stop = next_w_data[CMD_STOP_BIT];
        next_rd = next_w_data[CMD_READ_BIT];
        next_mack = next_w_data[CMD_ACK_BIT];
        next_tx = next_w_strb[1] ? next_w_data[CMD_DATA_LSB +: 8] : 8'h00;
        next_q = 2'h0;
        next_bitn = 4'h0;
        if (next_w_data[CMD_START_BIT]) begin
          next_state = HS_START;
        end else if (next_w_data[CMD_BYTE_BIT]) begin
          next_state = HS_BIT;
        end else if (next_w_data[CMD_STOP_BIT]) begin
          next_state = HS_STOP;
        end
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = 32'h0;
      next_rresp = RESP_OKAY;
      if (araddr == HOST_STAT_OFS) begin
        next_rdata[STAT_BUSY_BIT] = (state != HS_IDLE);
        next_rdata[STAT_NACK_BIT] = nack;
        next_rdata[STAT_DATA_LSB +: 8] = rx;
      end else if (araddr != HOST_CMD_OFS) begin
        next_rresp = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= HS_IDLE;
      q <= 2'h0;
      bitn <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      do_byte <= 1'b0;
      do_stop <= 1'b0;
      rd <= 1'b0;
      mack <= 1'b0;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      state <= next_state;
      q <= next_q;
      bitn <= next_bitn;
      tx <= next_tx;
      rx <= next_rx;
      do_byte <= next_do_byte;
      do_stop <= next_do_stop;
      rd <= next_rd;
      mack <= next_mack;
      nack <= next_nack;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe = scl_oe;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe = sda_oe;
endmodule : i2cx_host

// [hw/i2cx_pkg.sv]
/*
  Shared constants and state types for the 16-bit I2C port expander
  (device end) and its I2C master controller (host end).
  Assumes a single 100 MHz clock in both ends.
*/
package i2cx_pkg;
  // Upper five bits of the seven-bit bus address; the low two come from pins
  localparam logic [4:0] DEV_ADDR_BASE = 5'h1d;
  // Register pointer codes
  localparam logic [2:0] REG_INPUT0 = 3'h0;
  localparam logic [2:0] REG_INPUT1 = 3'h1;
  localparam logic [2:0] REG_LATCH0 = 3'h2;
  localparam logic [2:0] REG_LATCH1 = 3'h3;
  localparam logic [2:0] REG_INVERT0 = 3'h4;
  localparam logic [2:0] REG_INVERT1 = 3'h5;
  localparam logic [2:0] REG_DIRECTION0 = 3'h6;
  localparam logic [2:0] REG_DIRECTION1 = 3'h7;
  // Pair codes (pointer bits 2:1)
  localparam logic [1:0] PAIR_INPUT = 2'h0;
  localparam logic [1:0] PAIR_LATCH = 2'h1;
  localparam logic [1:0] PAIR_INVERT = 2'h2;
  localparam logic [1:0] PAIR_DIRECTION = 2'h3;
  // Reset values
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] INVERT_RST = 8'h00;
  localparam logic [7:0] DIRECTION_RST = 8'hff;
  localparam logic [2:0] POINTER_RST = 3'h0;
  // Host controller registers (AXI4-Lite byte offsets)
  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_STAT_OFS = 4'h4;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam int CMD_READ_BIT = 2;
  localparam int CMD_ACK_BIT = 3;
  localparam int CMD_BYTE_BIT = 4;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  typedef enum {
    DS_IDLE, DS_ADDR, DS_ADDR_END, DS_AACK, DS_RX, DS_RX_END, DS_WACK, DS_TX, DS_RACK
  } i2cx_dev_state_t;

  typedef enum {HS_IDLE, HS_START, HS_BIT, HS_STOP} i2cx_host_state_t;
endpackage : i2cx_pkg

// [hw/i2cx_if.sv]
/*
  Two-wire bus between the controller and the expander.
  Both lines are open-drain; the wired level is resolved here, idle high.
*/
interface i2cx_if;
  logic scl; // Resolved clock line
  logic sda; // Resolved data line
  logic host_scl_out; // Host clock value, always low
  logic host_scl_oe; // Host pulls clock
  logic host_sda_out; // Host data value, always low
  logic host_sda_oe; // Host pulls data
  logic dev_sda_out; // Device data value, always low
  logic dev_sda_oe; // Device pulls data

  assign scl = !(host_scl_oe && !host_scl_out);
  assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

  modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_out, output host_scl_oe,
    output host_sda_out, output host_sda_oe);
endinterface : i2cx_if

// [hw/i2cx_device.sv]
/*
  Expander end: bus slave, eight 8-bit registers in four port pairs,
  sixteen I/O pins and an open-drain change interrupt.
  Assumes the bus lines and pins are asynchronous to aclk and that the
  bus clock is far slower than aclk.
*/
module i2cx_device
  import i2cx_pkg::*;
(
  input logic aclk, // System clock
  input logic aresetn, // Synchronous reset, active low
  i2cx_if.dev bus, // Two-wire bus
  input logic addr_select_high, // Address pin, bit 1
  input logic addr_select_low, // Address pin, bit 0
  input logic [7:0] port_zero_pins_level, // Port 0 pin levels
  output logic [7:0] port_zero_pins_drive, // Port 0 drive values
  output logic [7:0] port_zero_pins_enable, // Port 0 driver enables
  input logic [7:0] port_one_pins_level, // Port 1 pin levels
  output logic [7:0] port_one_pins_drive, // Port 1 drive values
  output logic [7:0] port_one_pins_enable, // Port 1 driver enables
  output logic int_pin_out, // Interrupt value, always low
  output logic int_pin_enable // Interrupt pulled low
);
  localparam int SW = 20;

  logic [SW-1:0] raw, sync1, sync2, sync3, filt, next_filt;
  logic scl_l, sda_l, scl_q, sda_q, scl_rise, scl_fall, bus_start, bus_stop;
  logic [15:0] pins, lvl, pend;

  i2cx_dev_state_t state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shreg, next_shreg;
  logic rw, next_rw, first, next_first, acked, next_acked, sda_oe, next_sda_oe;
  logic [2:0] ptr, next_ptr;
  logic [15:0] latch, next_latch, invert, next_invert, drive_en, next_drive_en;
  logic [15:0] snap, next_snap;
  logic int_oe, next_int_oe;

  // Three-stage sampling; a bit changes once stages two and three agree
  assign raw = {addr_select_high, addr_select_low, bus.scl, bus.sda,
    port_one_pins_level, port_zero_pins_level};
  assign next_filt = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & filt);

  always_ff @(posedge aclk) begin
    sync1 <= raw;
    sync2 <= sync1;
    sync3 <= sync2;
    filt <= next_filt;
    scl_q <= scl_l;
    sda_q <= sda_l;
  end

  assign scl_l = filt[17];
  assign sda_l = filt[16];
  assign pins = filt[15:0];
  assign scl_rise = scl_l && !scl_q;
  assign scl_fall = !scl_l && scl_q;
  assign bus_start = scl_l && scl_q && sda_q && !sda_l;
  assign bus_stop = scl_l && scl_q && !sda_q && sda_l;
  assign lvl = pins ^ invert;
  assign pend = (pins ^ snap) & ~drive_en;

  // Byte of the selected register
  function automatic logic [7:0] rd_val(input logic [2:0] p);
    logic [15:0] v;
    begin
      case (p[2:1])
        PAIR_INPUT: v = lvl;
        PAIR_LATCH: v = latch;
        PAIR_INVERT: v = invert;
        default: v = ~drive_en;
      endcase
      rd_val = p[0] ? v[15:8] : v[7:0];
    end
  endfunction : rd_val

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_rw = rw;
    next_first = first;
    next_acked = acked;
    next_sda_oe = sda_oe;
    next_ptr = ptr;
    next_latch = latch;
    next_invert = invert;
    next_drive_en = drive_en;
    next_snap = snap;
    next_int_oe = |pend;
    if (bus_start) begin
      // Pointer already names the register in use at a restart
      next_state = DS_ADDR;
      next_cnt = 3'h0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_state = DS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        DS_IDLE: begin
        end
        DS_ADDR: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_l};
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7) begin
              next_state = DS_ADDR_END;
            end
          end
        end
        DS_ADDR_END: begin
          if (scl_fall) begin
            // General call has upper bits zero and never matches
            if (shreg[7:1] == {DEV_ADDR_BASE, filt[19:18]}) begin
              next_sda_oe = 1'b1;
              next_rw = shreg[0];
              next_state = DS_AACK;
            end else begin
              next_state = DS_IDLE;
            end
          end
        end
        DS_AACK: begin
          if (scl_rise && rw) begin
            next_shreg = rd_val(ptr);
            if (ptr[2:1] == PAIR_INPUT) begin
              next_snap[{ptr[0], 3'h0} +: 8] = pins[{ptr[0], 3'h0} +: 8];
            end
          end
          if (scl_fall) begin
            next_cnt = 3'h0;
            if (rw) begin
              next_sda_oe = !shreg[7];
              next_state = DS_TX;
            end else begin
              next_sda_oe = 1'b0;
              next_first = 1'b1;
              next_state = DS_RX;
            end
          end
        end
        DS_RX: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_l};
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7) begin
              next_state = DS_RX_END;
            end
          end
        end
        DS_RX_END: begin
          if (scl_fall) begin
            next_sda_oe = 1'b1;
            next_state = DS_WACK;
            if (first) begin
              next_ptr = shreg[2:0];
              next_first = 1'b0;
            end else begin
              case (ptr[2:1])
                PAIR_LATCH: next_latch[{ptr[0], 3'h0} +: 8] = shreg;
                PAIR_INVERT: next_invert[{ptr[0], 3'h0} +: 8] = shreg;
                PAIR_DIRECTION: next_drive_en[{ptr[0], 3'h0} +: 8] = ~shreg;
                default: begin
                end
              endcase
              next_ptr = {ptr[2:1], !ptr[0]};
            end
          end
        end
        DS_WACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 3'h0;
            next_state = DS_RX;
          end
        end
        DS_TX: begin
          if (scl_fall) begin
            if (cnt == 3'h7) begin
              next_sda_oe = 1'b0;
              next_state = DS_RACK;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = !shreg[6];
              next_cnt = cnt + 3'h1;
            end
          end
        end
        DS_RACK: begin
          if (scl_rise) begin
            next_acked = !sda_l;
            if (!sda_l) begin
              next_ptr = {ptr[2:1], !ptr[0]};
              next_shreg = rd_val({ptr[2:1], !ptr[0]});
              if (ptr[2:1] == PAIR_INPUT) begin
                next_snap[{!ptr[0], 3'h0} +: 8] = pins[{!ptr[0], 3'h0} +: 8];
              end
            end
          end
          if (scl_fall) begin
            next_cnt = 3'h0;
            next_sda_oe = acked && !shreg[7];
            next_state = acked ? DS_TX : DS_IDLE;
          end
        end
        default: next_state = DS_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= DS_IDLE;
      cnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      acked <= 1'b0;
      sda_oe <= 1'b0;
      ptr <= POINTER_RST;
      latch <= {LATCH_RST, LATCH_RST};
      invert <= {INVERT_RST, INVERT_RST};
      drive_en <= ~{DIRECTION_RST, DIRECTION_RST};
      snap <= pins;
      int_oe <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      first <= next_first;
      acked <= next_acked;
      sda_oe <= next_sda_oe;
      ptr <= next_ptr;
      latch <= next_latch;
      invert <= next_invert;
      drive_en <= next_drive_en;
      snap <= next_snap;
      int_oe <= next_int_oe;
    end
  end

  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe = sda_oe;
  assign port_zero_pins_drive = latch[7:0];
  assign port_one_pins_drive = latch[15:8];
  assign port_zero_pins_enable = drive_en[7:0];
  assign port_one_pins_enable = drive_en[15:8];
  assign int_pin_out = 1'b0;
  assign int_pin_enable = int_oe;
endmodule : i2cx_device

// [verif/i2cx_chk.sv]
/*
  Bus checker for the expander link.
  Assumes the resolved lines and enables of the bus are wired to it.
*/
module i2cx_chk (
  input logic aclk, // Clock
  input logic aresetn, // Reset, active low
  input logic scl, // Clock line
  input logic sda, // Data line
  input logic host_scl_oe, // Host pulls clock
  input logic host_sda_oe, // Host pulls data
  input logic dev_sda_oe // Device pulls data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_q, next_scl_q;
  logic [3:0] low_cnt, next_low_cnt;
  // Cycles since the clock line fell
  always_comb begin
    next_scl_q = scl;
    next_low_cnt = !aresetn ? 4'hf : (scl_q && !scl) ? 4'h0 :
      low_cnt + {3'h0, low_cnt != 4'hf};
  end
  always_ff @(posedge aclk) begin
    scl_q <= next_scl_q;
    low_cnt <= next_low_cnt;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_idle; $rose(aresetn) |-> !dev_sda_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("data pulled after reset");
  property p_rise_low; $rose(dev_sda_oe) |-> !scl; endproperty
  a_rise_low: assert property (p_rise_low) else $error("pull with clock high");
  property p_answer; $changed(dev_sda_oe) |-> low_cnt inside {[2:10]}; endproperty
  a_answer: assert property (p_answer) else $error("late data change");
  property p_hold; $rose(scl) |-> ##1 $stable(dev_sda_oe)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("data moved in clock high");
  property p_scl_low; $rose(host_scl_oe) |=> host_scl_oe[*7]; endproperty
  a_scl_low: assert property (p_scl_low) else $error("short clock low");
  property p_scl_high; $fell(host_scl_oe) |=> !host_scl_oe[*7]; endproperty
  a_scl_high: assert property (p_scl_high) else $error("short clock high");
  property p_release; $rose(scl) && dev_sda_oe |-> !host_sda_oe; endproperty
  a_release: assert property (p_release) else $error("both pull data");
  property p_cond; scl && $changed(sda) |-> !dev_sda_oe && !$past(dev_sda_oe); endproperty
  a_cond: assert property (p_cond) else $error("device held start or stop");
endmodule : i2cx_chk

// [verif/i2cx_tb_top.sv]
/*
  Self-checking bench: controller and expander joined on one bus.
  Assumes the hw/ files are compiled first.
*/
`define CK(a, e) begin tests_run++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, a, e); end end
module i2cx_tb_top
  import i2cx_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  int n_errors = 0, tests_run = 0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] asel = 2'h0, bresp, rresp;
  logic [7:0] ext0 = 8'h00, ext1 = 8'h00, drv0, en0, drv1, en1;
  logic awready, wready, bvalid, arready, rvalid, irq;
  i2cx_if bus ();
  i2cx_host #(.QUARTER(8)) i2cx_host_i (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  i2cx_device i2cx_device_i (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .addr_select_high(asel[1]), .addr_select_low(asel[0]),
    .port_zero_pins_level((en0 & drv0) | (~en0 & ext0)), .port_zero_pins_drive(drv0),
    .port_zero_pins_enable(en0), .port_one_pins_level((en1 & drv1) | (~en1 & ext1)),
    .port_one_pins_drive(drv1), .port_one_pins_enable(en1), .int_pin_out(),
    .int_pin_enable(irq));
  i2cx_chk i2cx_chk_i (.aclk(aclk), .aresetn(aresetn), .scl(bus.scl), .sda(bus.sda),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_oe(bus.dev_sda_oe));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr
  // One bus step: flags in f, then poll until idle
  task automatic bt(input logic [7:0] d, input logic [7:0] f, output logic [31:0] s);
    logic [1:0] r;
    axw(HOST_CMD_OFS, {16'h0000, d, f | 8'h10});
    do axr(HOST_STAT_OFS, s, r); while (s[STAT_BUSY_BIT] !== 1'b0);
  endtask : bt
  task automatic wseq(input logic [7:0] p, input logic [7:0] q[$]);
    logic [31:0] s;
    bt(8'he8, 8'h01, s);
    `CK(s[1], 1'b0)
    bt(p, 8'h00, s);
    `CK(s[1], 1'b0)
    foreach (q[i]) begin
      bt(q[i], (i == q.size() - 1) ? 8'h02 : 8'h00, s);
      `CK(s[1], 1'b0)
    end
  endtask : wseq
  // Negative p reads from the stored pointer
  task automatic rseq(input int p, input logic [7:0] e[$]);
    logic [31:0] s;
    if (p >= 0) begin
      bt(8'he8, 8'h01, s);
      bt(p[7:0], 8'h00, s);
    end
    bt(8'he9, 8'h01, s);
    `CK(s[1], 1'b0)
    foreach (e[i]) begin
      bt(8'hff, (i == e.size() - 1) ? 8'h06 : 8'h0c, s);
      `CK(s[15:8], e[i])
    end
  endtask : rseq
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    `CK({en1, en0}, 16'h0000)
    `CK({drv1, drv0}, 16'hffff)
    rseq(2, '{8'hff, 8'hff});
    rseq(4, '{8'h00, 8'h00});
    rseq(6, '{8'hff, 8'hff});
    axr(4'h8, d, r);
    `CK(r, RESP_SLVERR)
  endtask : t_reset
  task automatic t_write();
    wseq(3, '{8'ha5, 8'h3c, 8'h96});
    rseq(2, '{8'h3c, 8'h96});
    wseq(6, '{8'h0f});
    ext0 <= 8'h55;
    rseq(0, '{(8'hf0 & 8'h3c) | (8'h0f & 8'h55)});
    `CK(en0, 8'hf0)
    `CK(drv0, 8'h3c)
    rseq(2, '{8'h3c});
  endtask : t_write
  task automatic t_invert();
    ext1 <= 8'hc3;
    wseq(5, '{8'hff, 8'h0f});
    wseq(0, '{8'h00, 8'h00});
    rseq(0, '{8'h35 ^ 8'h0f, 8'hc3 ^ 8'hff});
    `CK(irq, 1'b0)
    // Port 1 input change; a port 0 read must leave it pending
    ext1 <= 8'h5a;
    rseq(0, '{8'h35 ^ 8'h0f});
    `CK(irq, 1'b1)
    rseq(1, '{8'h5a ^ 8'hff});
    `CK(irq, 1'b0)
    rseq(8'hfd, '{8'hff, 8'h0f});
    rseq(-1, '{8'h0f});
  endtask : t_invert
  task automatic t_addr();
    logic [31:0] s;
    for (int k = 0; k < 4; k++) begin
      asel <= k[1:0];
      bt(8'he8 + 8'(k * 2), 8'h03, s);
      `CK(s[1], 1'b0)
    end
    bt(8'he8, 8'h03, s);
    `CK(s[1], 1'b1)
    bt(8'h00, 8'h03, s);
    `CK(s[1], 1'b1)
    asel <= 2'h0;
  endtask : t_addr
  task automatic t_rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    t_reset();
  endtask : t_rst
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (5) @(posedge aclk);
    t_reset();
    t_write();
    t_invert();
    t_addr();
    t_rst();
    finish_test();
  end
  initial begin
    #800000;
    n_errors++;
    finish_test();
  end
endmodule : i2cx_tb_top
